// [verilog/freq_cfg_defs.svh]
`ifndef FREQ_CFG_DEFS_SVH
`define FREQ_CFG_DEFS_SVH

// Holding register addresses
`define REG_RANGE_ADDR     16'h0006
`define REG_TERM_ADDR      16'h0008
`define REG_GATE_ADDR      16'h0009
`define REG_AVG_ADDR       16'h000A

// Reset values
`define RANGE_RESET        2'h0
`define TERM_RESET         2'h0
`define GATE_RESET         4'h0
`define AVG_RESET          8'h01

// Field positions
`define RANGE_MSB          1
`define TERM_MSB           1
`define GATE_MSB           3
`define AVG_MSB            7

// Range codes
`define RANGE_50K          2'h0
`define RANGE_1K           2'h1
`define RANGE_100          2'h2
`define RANGE_EVENT        2'h3

// Termination codes
`define TERM_PULLUP        2'h0
`define TERM_PULLDOWN      2'h1
`define TERM_FLOAT         2'h2

// Gate codes
`define GATE_FULL_CODE     4'h0
`define GATE_MAX_CODE      4'h9
`define GATE_FULL_STEPS    4'hA

// Timing
`define CLK_FREQ_KHZ       100000
`define GATE_STEP_TIME_MS  100
`define GATE_STEP_CYCLES   (`GATE_STEP_TIME_MS * `CLK_FREQ_KHZ)
`define STEPS_PER_SECOND   36'h00000000A

`endif

// [verilog/freq_cfg_pkg.sv]
package freq_cfg_pkg;

   typedef logic [1:0]  range_t;
   typedef logic [1:0]  term_t;
   typedef logic [3:0]  gate_t;
   typedef logic [7:0]  avg_t;
   typedef logic [15:0] word_t;
   typedef logic [31:0] meas_t;

   typedef struct packed {
      range_t      mode;
      logic [31:0] tick;
      logic [3:0]  step;
      logic [31:0] edges;
      logic [39:0] acc;
      logic [7:0]  cyc;
      logic        armed;
      meas_t       result;
      logic        done;
   } chan_s;

   typedef struct packed {
      range_t      range;
      term_t       term;
      gate_t       gate;
      avg_t        avg;
      word_t       rdata;
      logic        rvalid;
      logic        rerr;
      logic        pull_up;
      logic        pull_down;
      chan_s [1:0] ch;
   } cfg_s;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sync_s;

endpackage

// [verilog/edge_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
   input  wire logic clk,   // System clock
   input  wire logic nrst,  // Async reset, active low
   input  wire logic pin,   // Raw input from outside
   output logic      rise   // One-cycle pulse per rising edge
);
   import freq_cfg_pkg::*;

   sync_s r;
   sync_s next_r;

   always_comb begin
      next_r    = r;
      next_r.s1 = pin;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // First stage feeds only the second one
   assign rise = r.s2 & ~r.s3;

endmodule

`default_nettype wire

// [verilog/freq_gate_period_config.sv]
// Notes on behaviour
// - Termination code picks pull-up, pull-down, none, reserved
// - Gate code 0 is 1.0s, 1-9 tenths
// - Averaging count is 8 bits, 1 to 255
// - Period result is average over configured cycles
// - Range code selects 50k, 1k, 100 Hz, events
`include "freq_cfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module freq_gate_period_config #(
   parameter int unsigned GATE_STEP_CYCLES = `GATE_STEP_CYCLES  // Cycles per 0.1 s gate step
) (
   input  wire logic                 clk,           // System clock, 100 MHz
   input  wire logic                 nrst,          // Async reset, active low
   input  wire logic [15:0]          reg_addr,      // Holding register address
   input  wire logic [15:0]          reg_wdata,     // Write data
   input  wire logic                 reg_wr,        // Write strobe
   input  wire logic                 reg_rd,        // Read strobe
   output freq_cfg_pkg::word_t       reg_rdata,     // Read data
   output logic                      reg_rvalid,    // Read data valid pulse
   output logic                      reg_err,       // Bad address or value pulse
   input  wire logic [1:0]           meas_in,       // Measured input pins
   output logic                      pullup_en,     // Pull-up to 5V on both inputs
   output logic                      pulldown_en,   // Pull-down to input_return_terminal
   output freq_cfg_pkg::range_t      range_mode,    // Active range code
   output freq_cfg_pkg::meas_t       ch0_result,    // Channel 0 result
   output freq_cfg_pkg::meas_t       ch1_result,    // Channel 1 result
   output logic                      ch0_done,      // Channel 0 new result pulse
   output logic                      ch1_done       // Channel 1 new result pulse
);
   import freq_cfg_pkg::*;

   // Last tick of one tenth-second step
   localparam logic [31:0] STEP_LAST = 32'(GATE_STEP_CYCLES - 1);

   cfg_s r;
   cfg_s next_r;
   logic [1:0] rise;

   for (genvar g = 0; g < 2; g++) begin : g_sync
      edge_sync u_sync (
         .clk  (clk),
         .nrst (nrst),
         .pin  (meas_in[g]),
         .rise (rise[g])
      );
   end

   function automatic logic [3:0] gate_steps(input gate_t code);
      if (code == `GATE_FULL_CODE) begin
         return `GATE_FULL_STEPS;
      end
      return code;
   endfunction

   // Edges over the gate times ten steps per second gives Hz
   // Ten times a 32-bit count still fits the 36-bit product
   function automatic meas_t freq_hz(input logic [31:0] edges, input logic [3:0] steps);
      logic [35:0] prod;
      prod = 36'(edges) * `STEPS_PER_SECOND;
      return 32'(prod / 36'(steps));
   endfunction

   // Zero would stall the average, so it counts as one
   function automatic logic [7:0] avg_count(input avg_t n);
      return (n == 8'h00) ? 8'h01 : n;
   endfunction

   // Wrapping adders shared by both channels; callers bound the counts except acc and the event edge count, which wrap
   function automatic logic [31:0] add32(input logic [31:0] x, input logic b);
      return x + 32'(b);
   endfunction

   function automatic logic [39:0] inc40(input logic [39:0] x);
      return x + 40'h00_0000_0001;
   endfunction

   function automatic logic [7:0] inc8(input logic [7:0] x);
      return x + 8'h01;
   endfunction

   function automatic logic [3:0] inc4(input logic [3:0] x);
      return x + 4'h1;
   endfunction

   always_comb begin
      logic [3:0]  steps;
      logic [7:0]  navg;
      logic [39:0] total;

      // Pulses default low so each stands one cycle
      next_r        = r;
      steps         = gate_steps(r.gate);
      navg          = avg_count(r.avg);
      total         = 40'h00_0000_0000;
      next_r.rvalid = 1'b0;
      next_r.rerr   = 1'b0;

      // Write wins when both strobes arrive together
      if (reg_wr) begin
         unique case (reg_addr)
            `REG_RANGE_ADDR: next_r.range = reg_wdata[`RANGE_MSB:0];
            `REG_TERM_ADDR:  next_r.term  = reg_wdata[`TERM_MSB:0];
            `REG_GATE_ADDR: begin
               if (reg_wdata[15:0] <= 16'(`GATE_MAX_CODE)) begin
                  next_r.gate = reg_wdata[`GATE_MSB:0];
               end else begin
                  next_r.rerr = 1'b1;
               end
            end
            `REG_AVG_ADDR: begin
               if (reg_wdata[15:8] == 8'h00 && reg_wdata[7:0] != 8'h00) begin
                  next_r.avg = reg_wdata[`AVG_MSB:0];
               end else begin
                  next_r.rerr = 1'b1;
               end
            end
            default: next_r.rerr = 1'b1;
         endcase
      end else if (reg_rd) begin
         next_r.rvalid = 1'b1;
         unique case (reg_addr)
            `REG_RANGE_ADDR: next_r.rdata = {14'h0000, r.range};
            `REG_TERM_ADDR:  next_r.rdata = {14'h0000, r.term};
            `REG_GATE_ADDR:  next_r.rdata = {12'h000, r.gate};
            `REG_AVG_ADDR:   next_r.rdata = {8'h00, r.avg};
            default: begin
               next_r.rdata = 16'h0000;
               next_r.rerr  = 1'b1;
            end
         endcase
      end

      // Registered so the resistor controls never glitch on a decode
      next_r.pull_up   = (next_r.term == `TERM_PULLUP);
      next_r.pull_down = (next_r.term == `TERM_PULLDOWN);

      for (int i = 0; i < 2; i++) begin
         next_r.ch[i].done = 1'b0;
         if (r.ch[i].mode != r.range) begin
            // Range change restarts the measurement from scratch
            next_r.ch[i]      = '0;
            next_r.ch[i].mode = r.range;
         end else begin
            unique case (r.range)
               `RANGE_50K: begin
                  next_r.ch[i].edges = add32(r.ch[i].edges, rise[i]);
                  next_r.ch[i].tick  = add32(r.ch[i].tick, 1'b1);
                  if (r.ch[i].tick >= STEP_LAST) begin
                     next_r.ch[i].tick = 32'h0000_0000;
                     next_r.ch[i].step = inc4(r.ch[i].step);
                     if (inc4(r.ch[i].step) >= steps) begin
                        // Edge on the closing tick still belongs to this gate
                        next_r.ch[i].result = freq_hz(add32(r.ch[i].edges, rise[i]), steps);
                        next_r.ch[i].done   = 1'b1;
                        next_r.ch[i].edges  = 32'h0000_0000;
                        next_r.ch[i].step   = 4'h0;
                     end
                  end
               end
               `RANGE_1K, `RANGE_100: begin
                  // Counting continues across the edge, so no cycle is lost
                  if (r.ch[i].armed) begin
                     next_r.ch[i].acc = inc40(r.ch[i].acc);
                  end
                  if (rise[i]) begin
                     if (!r.ch[i].armed) begin
                        next_r.ch[i].armed = 1'b1;
                        next_r.ch[i].acc   = 40'h00_0000_0000;
                        next_r.ch[i].cyc   = 8'h00;
                     end else if (inc8(r.ch[i].cyc) >= navg) begin
                        total               = inc40(r.ch[i].acc);
                        next_r.ch[i].result = 32'(total / 40'(navg));
                        next_r.ch[i].done   = 1'b1;
                        next_r.ch[i].acc    = 40'h00_0000_0000;
                        next_r.ch[i].cyc    = 8'h00;
                     end else begin
                        next_r.ch[i].cyc = inc8(r.ch[i].cyc);
                     end
                  end
               end
               `RANGE_EVENT: begin
                  // Averaging count plays no part here
                  if (rise[i]) begin
                     next_r.ch[i].edges  = add32(r.ch[i].edges, 1'b1);
                     next_r.ch[i].result = add32(r.ch[i].edges, 1'b1);
                     next_r.ch[i].done   = 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Settings come up at their defaults, all counts at zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r       <= '0;
         r.range <= `RANGE_RESET;
         r.term  <= `TERM_RESET;
         r.gate  <= `GATE_RESET;
         r.avg   <= `AVG_RESET;
         r.pull_up   <= (`TERM_RESET == `TERM_PULLUP);
         r.pull_down <= (`TERM_RESET == `TERM_PULLDOWN);
      end else begin
         r <= next_r;
      end
   end

   // Reserved termination code drives neither resistor
   assign pullup_en   = r.pull_up;
   assign pulldown_en = r.pull_down;
   assign range_mode  = r.range;
   assign reg_rdata   = r.rdata;
   assign reg_rvalid  = r.rvalid;
   assign reg_err     = r.rerr;
   assign ch0_result  = r.ch[0].result;
   assign ch1_result  = r.ch[1].result;
   assign ch0_done    = r.ch[0].done;
   assign ch1_done    = r.ch[1].done;

endmodule

`default_nettype wire

// [tb/freq_gate_period_config_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module freq_gate_period_config_sva (
   input wire logic                 clk,         // Clock
   input wire logic                 nrst,        // Reset
   input wire logic [15:0]          reg_addr,    // Address
   input wire logic [15:0]          reg_wdata,   // Data
   input wire logic                 reg_wr,      // Write
   input wire logic                 reg_err,     // Error
   input wire logic                 pullup_en,   // Pull-up
   input wire logic                 pulldown_en, // Pull-down
   input wire freq_cfg_pkg::range_t range_mode,  // Range
   input wire logic                 ch0_done,    // Done 0
   input wire logic                 ch1_done     // Done 1
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic       wt;
   logic       wg;
   logic       wa;
   logic       wr6;
   logic [1:0] wd2;
   assign wt = reg_wr && reg_addr == 16'h0008;
   assign wg = reg_wr && reg_addr == 16'h0009;
   assign wa = reg_wr && reg_addr == 16'h000A;
   assign wr6 = reg_wr && reg_addr == 16'h0006;
   assign wd2 = reg_wdata[1:0];
   a_term_decode: assert property (wt |=> pullup_en == ($past(wd2) == 2'h0) &&
      pulldown_en == ($past(wd2) == 2'h1)) else $error("termination decode wrong");
   a_term_excl: assert property (!(pullup_en && pulldown_en)) else $error("both pulls on");
   a_gate_refuse: assert property (wg && reg_wdata > 16'h0009 |=> reg_err) else $error("gate kept");
   a_gate_accept: assert property (wg && reg_wdata <= 16'h0009 |=> !reg_err) else $error("gate refused");
   a_avg_refuse: assert property (wa && (reg_wdata[15:8] != 8'h00 || reg_wdata == 16'h0000)
      |=> reg_err) else $error("average kept");
   a_avg_accept: assert property (wa && reg_wdata[15:8] == 8'h00 && reg_wdata != 16'h0000
      |=> !reg_err) else $error("average refused");
   a_range_write: assert property (wr6 |=> range_mode == $past(wd2)) else $error("range wrong");
   a_done_pulse: assert property (ch0_done |=> !ch0_done) else $error("done too long");
   cover property (wg && reg_wdata > 16'h0009);
   cover property (ch0_done && range_mode == 2'h1);
   cover property (ch1_done && range_mode == 2'h3);
endmodule
bind freq_gate_period_config freq_gate_period_config_sva u_sva (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_err(reg_err), .pullup_en(pullup_en),
   .pulldown_en(pulldown_en), .range_mode(range_mode), .ch0_done(ch0_done), .ch1_done(ch1_done));
`default_nettype wire

// [tb/reg_host.sv]
`timescale 1ns/1ps
`default_nettype none
module reg_host (
   input  wire logic                clk,       // Clock
   input  wire freq_cfg_pkg::word_t reg_rdata, // Read data
   input  wire logic                reg_rvalid,// Read valid
   input  wire logic                reg_err,   // Error
   output logic [15:0]              reg_addr,  // Address
   output logic [15:0]              reg_wdata, // Data
   output logic                     reg_wr,    // Write
   output logic                     reg_rd     // Read
);
   initial begin
      reg_addr = 16'hFFFF;
      reg_wdata = 16'hFFFF;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Released lines show the inverse so stale values cannot pass
   task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                         output logic [15:0] q, output logic e, output logic v);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      q = reg_rdata;
      e = reg_err;
      v = reg_rvalid;
   endtask
endmodule
`default_nettype wire

// [tb/freq_gate_period_config_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module freq_gate_period_config_tb;
   import freq_cfg_pkg::*;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [1:0]  meas_in = 2'h0;
   int          per = 0;
   int          errors = 0;
   int          checks_done = 0;
   logic [15:0] reg_addr, reg_wdata, q, g, n, d;
   logic        reg_wr, reg_rd, e, v, reg_rvalid, reg_err, pullup_en, pulldown_en, ch0_done, ch1_done;
   word_t       reg_rdata;
   range_t      range_mode;
   meas_t       ch0_result, ch1_result;
   logic [15:0] ra [4] = '{16'h0006, 16'h0008, 16'h0009, 16'h000A};
   logic [15:0] rv [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001};
   always #5 clk = ~clk;
   always begin
      @(negedge clk);
      if (per > 0) begin
         meas_in = 2'h3;
         repeat (2) @(negedge clk);
         meas_in = 2'h0;
         repeat (per - 3) @(negedge clk);
      end
   end
   reg_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
   freq_gate_period_config #(.GATE_STEP_CYCLES(10)) dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_err(reg_err), .meas_in(meas_in), .pullup_en(pullup_en), .pulldown_en(pulldown_en),
      .range_mode(range_mode), .ch0_result(ch0_result), .ch1_result(ch1_result), .ch0_done(ch0_done),
      .ch1_done(ch1_done));
   function automatic logic gate_ok(input logic [15:0] x);
      return x <= 16'h0009;
   endfunction
   function automatic logic avg_ok(input logic [15:0] x);
      return x[15:8] == 8'h00 && x != 16'h0000;
   endfunction
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] x);
      host.access(1'b1, a, x, q, e, v);
   endtask
   // Let the restart flush any result of the old range
   task automatic set_range(input logic [15:0] m);
      wr(16'h0006, m);
      repeat (2) @(negedge clk);
   endtask
   task automatic rd(input logic [15:0] a);
      host.access(1'b0, a, 16'h0000, q, e, v);
      chk(32'h1, v);
   endtask
   task automatic try(input logic [15:0] a, input logic [15:0] x, input logic ok, ref logic [15:0] keep);
      wr(a, x);
      chk(!ok, e);
      if (ok) keep = x;
      rd(a);
      chk(keep, q);
   endtask
   task automatic wait_done(input meas_t exp, input logic look);
      int k;
      k = 0;
      while (ch0_done !== 1'b1 && k < 3000) begin
         @(negedge clk);
         k++;
      end
      if (k >= 3000) chk(32'h1, ch0_done);
      if (look) chk(exp, ch0_result);
      if (look) chk(exp, ch1_result);
      if (look) chk(32'h1, ch1_done);
      @(negedge clk);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'hF63E));
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(ra[i]);
         chk(rv[i], q);
      end
      chk(32'h1, pullup_en);
      rd(16'h0007);
      chk(32'h1, e);
      chk(32'h0, q);
      for (int i = 0; i < 4; i++) begin
         wr(16'h0008, 16'(i));
         chk(i == 0, pullup_en);
         chk(i == 1, pulldown_en);
      end
      $display("test regs done");
      g = 16'h0000;
      n = 16'h0001;
      try(16'h0009, 16'h0100, 1'b0, g);
      try(16'h000A, 16'h0000, 1'b0, n);
      try(16'h000A, 16'h0100, 1'b0, n);
      try(16'h000A, 16'h00FF, 1'b1, n);
      for (int i = 0; i < 12; i++) begin
         d = 16'($urandom_range(15));
         try(16'h0009, d, gate_ok(d), g);
         d = 16'($urandom_range(300));
         try(16'h000A, d, avg_ok(d), n);
      end
      $display("test limits done");
      for (int i = 0; i < 4; i++) begin
         wr(16'h0006, 16'(i));
         chk(i, range_mode);
      end
      per = 6;
      wait_done(32'h1, 1'b1);
      wait_done(32'h2, 1'b1);
      $display("test events done");
      for (int m = 1; m <= 2; m++) begin
         per = $urandom_range(40, 16);
         wr(16'h000A, 16'($urandom_range(4, 1)));
         set_range(16'(m));
         wait_done(per, 1'b1);
      end
      $display("test period done");
      per = 5;
      // Old, longer pin period must die out before gates are counted
      repeat (48) @(negedge clk);
      wr(16'h0009, 16'($urandom_range(9)));
      set_range(16'h0000);
      wait_done(32'h0, 1'b0);
      wait_done(32'd20, 1'b1);
      $display("test gate done");
      give_verdict();
   end
endmodule
`default_nettype wire
